// ### design/dlcc_pkg.sv
// Shared constants and types for the downlink common channel formatter
package dlcc_pkg;
    // Frame and slot structure, counted in chips (one clock per chip)
    localparam int FRAME_TIME_MS      = 10;
    localparam int SLOTS_PER_FRAME    = 15;
    localparam int CHIPS_PER_SLOT_DEF = 2560;
    localparam int SCH_CHIPS          = 256;
    // Access slots span two chip slots
    localparam int AS_PER_RUN         = 15;
    localparam int AS_SYMS            = 40;
    localparam int AI_SYMS            = 32;
    localparam int NUM_SIGS           = 16;
    localparam logic AICH_START_PAR   = 1'b0;
    // Shared channel formats
    localparam logic [2:0]  PDSCH_FMT_MAX   = 3'h6;
    localparam logic [8:0]  PDSCH_SF_BASE   = 9'h100;
    localparam logic [10:0] PDSCH_BITS_BASE = 11'h014;
    localparam int FIFO_DEPTH_DEF     = 8;
    localparam int FIFO_WIDTH_DEF     = 8;
    // Reset values
    localparam logic [3:0] SLOT_RST  = 4'h0;
    localparam logic [2:0] FMT_RST   = 3'h0;

    typedef enum logic [1:0] {PH_SYNC = 2'b01, PH_BODY = 2'b10} slot_phase_t;
    typedef enum logic [1:0] {AP_IND = 2'b01, AP_IDLE = 2'b10} aich_part_t;

    // Antenna-2 pilot: symbols 0..7 of the 16-bit field, symbol 0 in the top bits
    function automatic logic [15:0] ant2_pilot(input logic [3:0] slot);
        case (slot)
            4'h0: ant2_pilot = 16'hC2C2;
            4'h1: ant2_pilot = 16'hC1E2;
            4'h2: ant2_pilot = 16'hF0E3;
            4'h3: ant2_pilot = 16'hE1C0;
            4'h4: ant2_pilot = 16'hF3D2;
            4'h5: ant2_pilot = 16'hC2F0;
            4'h6: ant2_pilot = 16'hE2D3;
            4'h7: ant2_pilot = 16'hE3E3;
            4'h8: ant2_pilot = 16'hC0D1;
            4'h9: ant2_pilot = 16'hD2D1;
            4'hA: ant2_pilot = 16'hF0C2;
            4'hB: ant2_pilot = 16'hD3C1;
            4'hC: ant2_pilot = 16'hE3F0;
            4'hD: ant2_pilot = 16'hD1E1;
            4'hE: ant2_pilot = 16'hD1F3;
            default: ant2_pilot = 16'hC000;
        endcase
    endfunction
endpackage

// ### design/downlink_common_channel_formatter.sv
// Downlink common channel formatter: SCH, antenna-2 pilots, shared channel, AICH
`timescale 1ns/100ps

module dlcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
    end

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];
    assign out_valid = (count != '0);

    // Occupancy; full is held in a flop so the fill side sees no deep logic
    always_comb begin
        next_count = count;
        if (push && !pop) next_count = count + 1'b1;
        if (pop && !push) next_count = count - 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count    <= '0;
            in_ready <= 1'b1;
            wr_ptr   <= '0;
            rd_ptr   <= '0;
        end else begin
            count    <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Storage has no reset: only words below the count are ever read
    always_ff @(posedge clock) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule

module downlink_common_channel_formatter
    import dlcc_pkg::*;
#(
    parameter int CHIPS_PER_SLOT = CHIPS_PER_SLOT_DEF,
    parameter int DATA_WIDTH     = FIFO_WIDTH_DEF,
    parameter int FIFO_DEPTH     = FIFO_DEPTH_DEF,
    parameter logic [NUM_SIGS*AI_SYMS-1:0] SIG_TABLE = '0
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // Configuration from higher layers
    input  wire logic                  div_ant_present,
    input  wire logic                  sccpch_ol_div,
    input  wire logic                  pccpch_sttd,
    input  wire logic                  sch_tstd,
    input  wire logic                  pdsch_ol_div,
    input  wire logic                  aich_sttd,
    input  wire logic                  aich_cd,
    input  wire logic [5:0]            scr_group,
    input  wire logic [2:0]            pdsch_fmt,
    input  wire logic [9:0]            pdsch_tfci,
    // Sync code chips from the code generators, 1 means +1
    input  wire logic                  psc_chip,
    input  wire logic                  ssc_chip,
    // S-CCPCH pilot request
    input  wire logic                  pilot_len16,
    input  wire logic [2:0]            pilot_sym_idx,
    // Acquisition indicators, +1 and -1 flags per signature
    input  wire logic [NUM_SIGS-1:0]   ai_pos,
    input  wire logic [NUM_SIGS-1:0]   ai_neg,
    // Shared channel data stream
    input  wire logic [DATA_WIDTH-1:0] pdsch_in_data,
    input  wire logic                  pdsch_in_valid,
    output logic                       pdsch_in_ready,
    output logic [DATA_WIDTH-1:0]      pdsch_out_data,
    output logic                       pdsch_out_valid,
    input  wire logic                  pdsch_out_ready,
    // Frame timing
    output logic                       frame_start,
    output logic                       sfn_odd,
    output logic [3:0]                 slot_num,
    output logic [7:0]                 sch_chip_idx,
    output logic [5:0]                 ssc_group,
    // SCH and P-CCPCH
    output logic                       sch_psc_out,
    output logic                       sch_ssc_out,
    output logic                       sch_ant1_en,
    output logic                       sch_ant2_en,
    output logic                       pccpch_en,
    // S-CCPCH diversity
    output logic [1:0]                 ant2_pilot_sym,
    output logic                       sccpch_sttd_on,
    // Shared channel control
    output logic [8:0]                 pdsch_sf,
    output logic [10:0]                pdsch_bits_slot,
    output logic [9:0]                 dpch_tfci,
    output logic                       pdsch_sttd_on,
    // AICH
    output logic signed [5:0]          aich_ant1_sym,
    output logic signed [5:0]          aich_ant2_sym,
    output logic                       aich_sym_strobe,
    output logic [3:0]                 aich_slot,
    output logic                       aich_chan_cd
);
    localparam int SYM_CHIPS = (2 * CHIPS_PER_SLOT) / AS_SYMS;
    localparam int CW = $clog2(CHIPS_PER_SLOT);

    initial begin
        if (CHIPS_PER_SLOT % AS_SYMS != 0 || CHIPS_PER_SLOT <= SCH_CHIPS)
            $error("CHIPS_PER_SLOT cannot carve sync part and AICH symbols");
    end

    // Weighted signature sum for one symbol, STTD applied per sequence first
    function automatic logic signed [5:0] ai_sum(input logic [NUM_SIGS-1:0] pos,
                                                 input logic [NUM_SIGS-1:0] neg,
                                                 input logic [5:0] j,
                                                 input logic sttd);
        logic signed [5:0] acc;
        logic [5:0]        src;
        logic              flip;
        logic              b;
        acc  = '0;
        src  = j;
        flip = 1'b0;
        if (sttd) begin
            case (j[1:0])
                2'h0: begin src = j + 6'h02; flip = 1'b1; end
                2'h1: src = j + 6'h02;
                2'h2: src = j - 6'h02;
                default: begin src = j - 6'h02; flip = 1'b1; end
            endcase
        end
        for (int s = 0; s < NUM_SIGS; s++) begin
            b = SIG_TABLE[s*AI_SYMS + int'(src[4:0])] ^ flip;
            if (pos[s]) acc = b ? acc + 6'sh01 : acc - 6'sh01;
            if (neg[s]) acc = b ? acc - 6'sh01 : acc + 6'sh01;
        end
        return acc;
    endfunction

    logic [CW-1:0]        chip_cnt;
    logic [$clog2(SYM_CHIPS)-1:0] sym_chip;
    logic [5:0]           sym_idx;
    logic [NUM_SIGS-1:0]  ai_pos_q;
    logic [NUM_SIGS-1:0]  ai_neg_q;
    logic                 slot_end;
    logic                 frame_end;
    logic                 sym_end;
    logic                 slot_tstd_ant2;
    logic [15:0]          pilot_row;
    slot_phase_t          phase;
    aich_part_t           aich_part;

    assign slot_end  = (chip_cnt == CW'(CHIPS_PER_SLOT - 1));
    assign frame_end = slot_end && (slot_num == 4'(SLOTS_PER_FRAME - 1));
    assign sym_end   = (sym_chip == ($bits(sym_chip))'(SYM_CHIPS - 1));

    // Chip and slot counters shared by every channel, so all frames align
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            chip_cnt    <= '0;
            slot_num    <= SLOT_RST;
            sfn_odd     <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            chip_cnt    <= slot_end ? '0 : chip_cnt + 1'b1;
            frame_start <= frame_end;
            if (slot_end) slot_num <= frame_end ? SLOT_RST : slot_num + 1'b1;
            if (frame_end) sfn_odd <= ~sfn_odd;
        end
    end

    // Slot phase: sync part in the first chips, body after
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase <= PH_SYNC;
        end else begin
            case (phase)
                PH_SYNC: if (chip_cnt == CW'(SCH_CHIPS - 1)) phase <= PH_BODY;
                PH_BODY: if (slot_end) phase <= PH_SYNC;
                default: phase <= PH_SYNC;
            endcase
        end
    end

    assign slot_tstd_ant2 = sch_tstd && slot_num[0];

    // Sync outputs; code chips arrive for the index shown one cycle earlier
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sch_chip_idx <= '0;
            ssc_group    <= '0;
            sch_psc_out  <= 1'b0;
            sch_ssc_out  <= 1'b0;
            sch_ant1_en  <= 1'b0;
            sch_ant2_en  <= 1'b0;
            pccpch_en    <= 1'b0;
        end else begin
            sch_chip_idx <= chip_cnt[7:0];
            ssc_group    <= scr_group;
            // XNOR with the sign: -1 inverts the chip when P-CCPCH has no STTD
            sch_psc_out  <= ~(psc_chip ^ pccpch_sttd);
            sch_ssc_out  <= ~(ssc_chip ^ pccpch_sttd);
            sch_ant1_en  <= (phase == PH_SYNC) && !slot_tstd_ant2;
            sch_ant2_en  <= (phase == PH_SYNC) && slot_tstd_ant2;
            pccpch_en    <= (phase == PH_BODY);
        end
    end

    assign pilot_row = ant2_pilot(slot_num);

    // Antenna-2 pilot lookup; short field takes the row's first four symbols
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ant2_pilot_sym <= 2'h0;
            sccpch_sttd_on <= 1'b0;
        end else begin
            ant2_pilot_sym <= pilot_row[15 - 2*int'(pilot_len16 ? pilot_sym_idx
                                          : {1'b0, pilot_sym_idx[1:0]}) -: 2];
            sccpch_sttd_on <= div_ant_present && sccpch_ol_div;
        end
    end

    // Shared channel format, taken only at frame boundaries
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pdsch_sf        <= PDSCH_SF_BASE;
            pdsch_bits_slot <= PDSCH_BITS_BASE;
            dpch_tfci       <= '0;
            pdsch_sttd_on   <= 1'b0;
        end else if (frame_end) begin
            // Out of range formats clamp to the fastest legal one
            pdsch_sf        <= PDSCH_SF_BASE >> ((pdsch_fmt > PDSCH_FMT_MAX)
                               ? PDSCH_FMT_MAX : pdsch_fmt);
            pdsch_bits_slot <= PDSCH_BITS_BASE << ((pdsch_fmt > PDSCH_FMT_MAX)
                               ? PDSCH_FMT_MAX : pdsch_fmt);
            dpch_tfci       <= pdsch_tfci;
            pdsch_sttd_on   <= pdsch_ol_div;
        end
    end

    logic [DATA_WIDTH-1:0] fifo_data;
    logic                  fifo_valid;
    logic                  fifo_pop;

    // Shared channel data holds payload only; control leaves via dpch_tfci
    dlcc_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_data   (pdsch_in_data),
        .in_valid  (pdsch_in_valid),
        .in_ready  (pdsch_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign fifo_pop = fifo_valid && (!pdsch_out_valid || pdsch_out_ready);

    // Output stage keeps the stream outputs on flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pdsch_out_valid <= 1'b0;
            pdsch_out_data  <= '0;
        end else if (!pdsch_out_valid || pdsch_out_ready) begin
            pdsch_out_valid <= fifo_valid;
            if (fifo_valid) pdsch_out_data <= fifo_data;
        end
    end

    // Access slot timing, restarted by each even-SFN frame
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sym_chip  <= '0;
            sym_idx   <= '0;
            aich_slot <= '0;
            aich_part <= AP_IND;
        end else if (frame_end && (sfn_odd != AICH_START_PAR)) begin
            sym_chip  <= '0;
            sym_idx   <= '0;
            aich_slot <= '0;
            aich_part <= AP_IND;
        end else if (sym_end) begin
            sym_chip <= '0;
            case (aich_part)
                AP_IND: begin
                    sym_idx <= sym_idx + 1'b1;
                    if (sym_idx == 6'(AI_SYMS - 1)) aich_part <= AP_IDLE;
                end
                AP_IDLE: begin
                    sym_idx <= (sym_idx == 6'(AS_SYMS - 1)) ? '0 : sym_idx + 1'b1;
                    if (sym_idx == 6'(AS_SYMS - 1)) begin
                        aich_part <= AP_IND;
                        aich_slot <= (aich_slot == 4'(AS_PER_RUN - 1)) ? '0
                                     : aich_slot + 1'b1;
                    end
                end
                default: aich_part <= AP_IND;
            endcase
        end else begin
            sym_chip <= sym_chip + 1'b1;
        end
    end

    // Indicators are frozen per access slot so all 32 symbols agree
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ai_pos_q <= '0;
            ai_neg_q <= '0;
        end else if (sym_chip == '0 && sym_idx == '0) begin
            ai_pos_q <= ai_pos & ~ai_neg;
            ai_neg_q <= ai_neg & ~ai_pos;
        end
    end

    // Symbol values; trailing part forced to zero for determinism
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aich_ant1_sym   <= '0;
            aich_ant2_sym   <= '0;
            aich_sym_strobe <= 1'b0;
            aich_chan_cd    <= 1'b0;
        end else begin
            aich_sym_strobe <= (sym_chip == '0);
            aich_chan_cd    <= aich_cd;
            if (aich_part == AP_IND) begin
                aich_ant1_sym <= ai_sum(ai_pos_q, ai_neg_q, sym_idx, 1'b0);
                aich_ant2_sym <= aich_sttd ? ai_sum(ai_pos_q, ai_neg_q, sym_idx, 1'b1)
                                 : 6'sh00;
            end else begin
                aich_ant1_sym <= '0;
                aich_ant2_sym <= '0;
            end
        end
    end

    // Checks
    AST_SLOT_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
        slot_end |=> chip_cnt == '0) else $error("slot did not wrap");
    AST_FRAME_SLOTS: assert property (@(posedge clock) disable iff (!reset_n)
        frame_end |=> slot_num == 4'h0 ##0 frame_start) else $error("frame wrap");
    AST_SYNC_LEN: assert property (@(posedge clock) disable iff (!reset_n)
        (chip_cnt == '0) |=> (sch_ant1_en || sch_ant2_en) && !pccpch_en)
        else $error("sync part missing");
    AST_BODY: assert property (@(posedge clock) disable iff (!reset_n)
        (chip_cnt == CW'(SCH_CHIPS)) |=> pccpch_en && !sch_ant1_en && !sch_ant2_en)
        else $error("sync overran 256 chips");
    AST_TSTD: assert property (@(posedge clock) disable iff (!reset_n)
        (sch_tstd && slot_num[0] && chip_cnt == '0) |=> sch_ant2_en && !sch_ant1_en)
        else $error("odd slot not on antenna 2");
    AST_SIGN: assert property (@(posedge clock) disable iff (!reset_n)
        !pccpch_sttd && $stable(pccpch_sttd) |=> sch_psc_out == !$past(psc_chip))
        else $error("sync sign wrong");
    AST_PILOT: assert property (@(posedge clock) disable iff (!reset_n)
        (pilot_sym_idx == 3'h2) |=> ant2_pilot_sym == 2'h0) else $error("pilot sym2");
    AST_PILOT0: assert property (@(posedge clock) disable iff (!reset_n)
        (pilot_sym_idx == 3'h0) |=> ant2_pilot_sym == 2'h3) else $error("pilot sym0");
    AST_STTD_SC: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 sccpch_sttd_on == $past(div_ant_present && sccpch_ol_div))
        else $error("S-CCPCH STTD flag");
    AST_SF_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
        pdsch_sf >= 9'h004 && $onehot(pdsch_sf)) else $error("bad SF");
    AST_SF_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        !$past(frame_end) |-> $stable(pdsch_sf)) else $error("SF changed mid frame");
    AST_AICH0: assert property (@(posedge clock) disable iff (!reset_n)
        (frame_end && sfn_odd) |=> sym_idx == '0 && aich_slot == '0 && sym_chip == '0)
        else $error("access slot 0 misaligned");
    AST_TAIL_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
        (aich_part == AP_IDLE) |=> aich_ant1_sym == '0) else $error("tail not zero");
    AST_FIFO_BP: assert property (@(posedge clock) disable iff (!reset_n)
        pdsch_out_valid && !pdsch_out_ready |=> pdsch_out_valid && $stable(pdsch_out_data))
        else $error("output dropped under stall");

    COV_TSTD_ODD: cover property (@(posedge clock) disable iff (!reset_n)
        sch_ant2_en);
    COV_FRAME: cover property (@(posedge clock) disable iff (!reset_n)
        frame_start && sfn_odd);
    COV_AICH_TAIL: cover property (@(posedge clock) disable iff (!reset_n)
        aich_part == AP_IDLE);
    COV_FIFO_FULL: cover property (@(posedge clock) disable iff (!reset_n)
        !pdsch_in_ready);
endmodule

// ### dv/dlcc_sink.sv
// Downstream sink model for the shared channel stream
`timescale 1ns/100ps
module dlcc_sink #(parameter int W = 8) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset_n,
    // Stream from the formatter
    input  wire logic [W-1:0] data,
    input  wire logic         valid,
    output logic              ready = 0,
    // Accepted word, seen one cycle later
    output logic              got = 0,
    output logic [W-1:0]      got_data
);
    int seed = 32'h1ed5;
    int n    = 0;
    // Long stall first so the buffer fills, then random back-pressure
    always @(posedge clock) begin
        got      <= valid && ready && reset_n;
        got_data <= data;
        n        <= n + 1;
        #10 ready <= (n > 70) && ($random(seed) % 3 != 0);
    end
endmodule

// ### dv/test_downlink_common_channel_formatter.sv
// Self-checking bench for the downlink common channel formatter
`timescale 1ns/100ps
module test_downlink_common_channel_formatter;
    import dlcc_pkg::*;
    logic clock = 0, reset_n = 0, psc_chip = 1, ssc_chip = 0, pilot_len16 = 0;
    logic div_ant_present = 0, sccpch_ol_div = 0, pccpch_sttd = 0, sch_tstd = 0;
    logic pdsch_ol_div = 0, aich_sttd = 0, aich_cd = 0, pdsch_in_valid = 0, rdy, got;
    logic pdsch_in_ready, pdsch_out_valid, frame_start, sch_psc_out, sch_ssc_out;
    logic sch_ant1_en, sch_ant2_en, pccpch_en, sccpch_sttd_on, pdsch_sttd_on;
    logic aich_sym_strobe, aich_chan_cd, p_strobe = 0, sfn_odd, live = 0;
    logic [15:0] ai_pos = 16'h0107, ai_neg = 16'h0110;
    logic [7:0]  pdsch_in_data = 8'h00, pdsch_out_data, got_data, sch_chip_idx, q[$];
    logic [5:0]  scr_group = 6'h00, ssc_group;
    logic [2:0]  pdsch_fmt = 3'h0, pilot_sym_idx = 3'h1, p_idx = 3'h1;
    logic [9:0]  pdsch_tfci = 10'h000, dpch_tfci;
    logic [3:0]  slot_num, aich_slot, last_slot = 4'hF;
    logic [1:0]  ant2_pilot_sym;
    logic [8:0]  pdsch_sf;
    logic [10:0] pdsch_bits_slot;
    logic signed [5:0] aich_ant1_sym, aich_ant2_sym;
    int fails = 0, n_checks = 0, seed = 32'h1ed5, gap = 0, en_cnt = 0, j = 0;
    int pushed = 0, started = 0;
    bit acc, parity = 0;

    downlink_common_channel_formatter #(.CHIPS_PER_SLOT(280)) DUT (.*,
        .pdsch_out_ready(rdy));
    dlcc_sink #(.W(8)) sink (.clock(clock), .reset_n(reset_n), .data(pdsch_out_data),
        .valid(pdsch_out_valid), .ready(rdy), .got(got), .got_data(got_data));

    always #50 clock = ~clock;

    // Outputs are only meaningful once an edge has seen reset released
    always @(posedge clock) live <= reset_n;

    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (e !== s) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Bounded wait for the next frame start; a hang ends the run
    task automatic wait_frame();
        int k = 0;
        do begin @(posedge clock); #10; k++; end while (frame_start !== 1'b1 && k < 5000);
        if (k >= 5000) begin fails++; conclude(); end
    endtask

    // Watcher: frame timing, sync part, pilots, indicators, stream words
    always @(negedge clock) if (live) begin
        gap++;
        if (frame_start) begin
            if (started) chk("frame_len", 16'd4200, gap);
            if (started) chk("sync_chips", 16'd3840, en_cnt);
            started = 1; gap = 0; en_cnt = 0;
            parity = !parity;
            chk("sfn_odd", parity, sfn_odd);
            if (!parity) chk("aich_slot0", 4'h0, aich_slot);
        end
        en_cnt += sch_ant1_en | sch_ant2_en;
        if ((sch_ant1_en | sch_ant2_en) && sch_chip_idx > 8'h02) begin
            chk("psc", pccpch_sttd, sch_psc_out);
            chk("ssc", !pccpch_sttd, sch_ssc_out);
            chk("ant2", sch_tstd & slot_num[0], sch_ant2_en);
        end
        chk("pccpch_en", !(sch_ant1_en | sch_ant2_en), pccpch_en);
        if (p_idx[1:0] == 2'h0) chk("pilot_s0", 2'h3, ant2_pilot_sym);
        if (p_idx[1:0] == 2'h2) chk("pilot_s2", 2'h0, ant2_pilot_sym);
        p_idx = pilot_sym_idx;
        if (p_strobe) begin
            j = (aich_slot != last_slot) ? 0 : j + 1;
            last_slot = aich_slot;
            chk("aich", (j < 32) ? 6'h3E : 6'h00, $unsigned(aich_ant1_sym));
            chk("aich2", (j >= 32 || !aich_sttd) ? 6'h00 : (j % 4 == 0 || j % 4 == 3)
                ? 6'h02 : 6'h3E, $unsigned(aich_ant2_sym));
        end
        p_strobe = aich_sym_strobe;
        if (got) chk("pdsch_word", q.pop_front(), got_data);
    end

    // Stream driver: random words held until taken, noted when accepted
    initial begin
        @(posedge reset_n);
        forever begin
            acc = pdsch_in_valid && pdsch_in_ready;
            @(posedge clock);
            if (acc) begin q.push_back(pdsch_in_data); pushed++; end
            #10;
            if (!pdsch_in_valid || acc) pdsch_in_valid = ($random(seed) % 4 != 0);
            if (!pdsch_in_valid || acc) pdsch_in_data = $random(seed);
            pilot_len16 = $random(seed);
            pilot_sym_idx = $random(seed);
        end
    end

    // Main sequence: reset, fill while stalled, then one format per frame pair
    initial begin
        @(posedge clock); #10;
        chk("sf_rst", 9'h100, pdsch_sf);
        chk("bits_rst", 11'h014, pdsch_bits_slot);
        @(posedge clock); #10 reset_n = 1;
        repeat (60) @(posedge clock);
        #10 chk("full", 1'b0, pdsch_in_ready);
        chk("filled", 1'b1, pushed >= 8);
        // Configuration only moves at frame starts, away from checked sync chips
        wait_frame();
        for (int f = 0; f < 8; f++) begin
            pdsch_fmt = f;
            pdsch_tfci = $random(seed);
            scr_group = $random(seed);
            {div_ant_present, sccpch_ol_div, pccpch_sttd, sch_tstd, pdsch_ol_div,
                aich_sttd, aich_cd} = $random(seed);
            wait_frame();
            wait_frame();
            chk("sf", 9'h100 >> ((f > 6) ? 6 : f), pdsch_sf);
            chk("bits", 11'h014 << ((f > 6) ? 6 : f), pdsch_bits_slot);
            chk("tfci", pdsch_tfci, dpch_tfci);
            chk("sccpch_sttd", div_ant_present & sccpch_ol_div, sccpch_sttd_on);
            chk("pdsch_sttd", pdsch_ol_div, pdsch_sttd_on);
            chk("chan_cd", aich_cd, aich_chan_cd);
            chk("group", scr_group, ssc_group);
        end
        conclude();
    end
endmodule
